// [core/flash_ctl_defs.svh]
// Constants for the parallel flash command controller.
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// Clock rate and time-to-cycle conversion (least times round up).
`define CLK_MHZ 100
`define NS2CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define US2CYC(us) ((us) * `CLK_MHZ)

// Bus cycle times, in nanoseconds or microseconds as printed, and the data line synchroniser depth.
`define SETUP_NS 20
`define WE_LOW_NS 50
`define REC_NS 30
`define RD_ACC_NS 120
`define PROT_PULSE_US 10
`define SYNC_STAGES 2

// Command codes written on the low data byte.
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_ID 8'h90
`define CMD_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_PROT_UNLOCK 8'h20
`define CMD_RESET 8'hF0

// Unlock addresses on A10..A0 (word) or A10..A-1 (byte).
`define UL1_W 11'h555
`define UL2_W 11'h2AA
`define UL1_B 12'hAAA
`define UL2_B 12'h555

// Bit positions in the pin address {A17..A0, A-1}.
`define FA_A9 10
`define FA_A6 7
`define FA_A1 2
`define FA_SEC_HI 18
`define FA_SEC_LO 13

// Status bits read back from the device data lines.
`define DQ_POLL 7
`define DQ_TOGGLE 6
`define DQ_TIMEOUT 5

// Software register byte offsets.
`define REG_CTRL 4'h0
`define REG_ADDR 4'h4
`define REG_STATUS 4'h8
`define REG_DATA 4'hC

// Control and status field positions.
`define CTRL_BYTE 4
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_POLL 3
`define ST_TOGGLE 4
`define ST_TIMEOUT 5

`endif

// [core/flash_pkg.sv]
// Types shared by the parallel flash command controller.
package flash_pkg;

	// Operations that software can start.
	typedef enum logic [3:0] {
		OP_READ      = 4'h0,
		OP_RESET     = 4'h1,
		OP_ID        = 4'h2,
		OP_ERASE     = 4'h3,
		OP_LV_PROT   = 4'h4,
		OP_LV_UNPROT = 4'h5,
		OP_HV_PROT   = 4'h6,
		OP_HV_UNPROT = 4'h7,
		OP_HV_ID     = 4'h8
	} op_t;

	// Kinds of a single bus step.
	typedef enum logic [2:0] {
		K_END     = 3'b000,
		K_WR      = 3'b001,
		K_RD      = 3'b010,
		K_POLL    = 3'b011,
		K_LVPULSE = 3'b100,
		K_HVPULSE = 3'b101,
		K_LVVER   = 3'b110,
		K_HVRD    = 3'b111
	} kind_t;

	// Bus cycle sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_ASSERT = 2'b10,
		ST_HOLD   = 2'b11
	} state_t;

	// One bus step: kind, pin address {A17..A0, A-1} and command byte.
	typedef struct packed {
		kind_t       kind;
		logic [18:0] addr;
		logic [7:0]  data;
	} step_t;

	// Everything the controller drives toward the flash device.
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        byte_n;
		logic [18:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe_n;
		logic        id_high_voltage_a9;
		logic        id_high_voltage_oe;
	} pins_t;

endpackage

// [core/flash_ctl.sv]
// Host-side controller that drives a parallel flash through its pins.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.svh"

// What this block does
// RULE1: Device drops bad sequences to array read.
// RULE2: Suspend and resume only during sector erase.
// RULE3: Reset command keeps device in array read.
// RULE4: After failure write reset, then new command.
// RULE5: ID command then reads maker/device code.
// RULE6: High voltage on select line reads ID.
// RULE7: Verify read returns 01 protected, 00 not.
// RULE8: Sector taken from six top address bits.
// RULE9: Unlock sequence precedes low-voltage protect.
// RULE10: Low-voltage verify only directly after protect.
// RULE11: Low-voltage pulse protects or unprotects.
// RULE12: High-voltage pulse protects or unprotects.
// RULE13: Chip erase uses exact six-write order.
// RULE14: Device pre-programs and erases by itself.
// RULE15: Erase starts on last strobe rising edge.
// RULE16: Erase ends itself without verify command.
// RULE17: Completion shows poll one, toggle stops.
// RULE18: Timeout bit set when erase fails.
// RULE19: Unlock addresses follow word or byte pattern.
// RULE20: Device latches address falling, data rising.
// RULE21: Busy device ignores commands except suspend.
// RULE22: Reset returns ID and verify to array.
module flash_ctl #(
	parameter int MAX_POLLS = 65535
) (
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire logic [3:0]     reg_addr,
	input  wire logic [31:0]    reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic [31:0]         reg_rdata,
	output flash_pkg::pins_t    pins,
	input  wire logic [15:0]    dq_in
);
	import flash_pkg::*;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam logic [10:0] SETUP_CYC = 11'(`NS2CYC(`SETUP_NS));
	localparam logic [10:0] WE_CYC    = 11'(`NS2CYC(`WE_LOW_NS));
	localparam logic [10:0] REC_CYC   = 11'(`NS2CYC(`REC_NS));
	localparam logic [10:0] RD_CYC    = 11'(`NS2CYC(`RD_ACC_NS) + `SYNC_STAGES);
	localparam logic [10:0] PULSE_CYC = 11'(`US2CYC(`PROT_PULSE_US));

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t      state_q, state_d;   // Sequencer state.
	op_t         op_q, op_d;         // Operation being run.
	logic [3:0]  idx_q, idx_d;       // Step index within the operation.
	logic [10:0] cnt_q, cnt_d;       // Cycles left in the current phase.
	logic        adv_q, adv_d;       // Step index advances after hold.
	logic        byte_q, byte_d;     // Byte mode selected.
	logic [18:0] taddr_q, taddr_d;   // Target pin address.
	logic        busy_q, busy_d;     // Operation in progress.
	logic        done_q, done_d;     // Last operation finished.
	logic        fail_q, fail_d;     // Last erase failed.
	logic        poll_q, poll_d;     // Last polled poll_bit.
	logic        tog_q, tog_d;       // Last polled toggle_bit.
	logic        tmo_q, tmo_d;       // Last polled timeout_bit.
	logic        first_q, first_d;   // No poll read taken yet.
	logic [15:0] polls_q, polls_d;   // Poll reads taken.
	logic [15:0] data_q, data_d;     // Last data read from the device.
	logic [31:0] rdata_q, rdata_d;   // Register read data.
	pins_t       pins_q, pins_d;     // Registered pin drive.
	logic [15:0] dq_s1_q, dq_s2_q;   // Data line synchroniser.
	logic [39:0] hist_q, hist_d;     // Last five command bytes written.
	logic        lvp_q, lvp_d;       // Low-voltage pulse was the last write strobe.
	step_t       cur, nxt;           // Current and next step.
	logic        wr_end;             // A command write ends this cycle.

	// Six-cycle unlock pattern with two command codes.
	function automatic step_t unl(input logic [3:0] i, input logic bm,
		input logic [7:0] c1, input logic [7:0] c2);
		step_t s;
		s.kind = K_WR;
		s.addr = bm ? {7'h00, `UL1_B} : {7'h00, `UL1_W, 1'b0}; // RULE19
		s.data = (i == 4'h2) ? c1 : (i == 4'h5) ? c2 : `CMD_UNLOCK1;
		if (i == 4'h1 || i == 4'h4) begin
			s.addr = bm ? {7'h00, `UL2_B} : {7'h00, `UL2_W, 1'b0}; // RULE19
			s.data = `CMD_UNLOCK2;
		end
		return s;
	endfunction

	// Step table for every operation.
	function automatic step_t step_of(input op_t op, input logic [3:0] i,
		input logic bm, input logic [18:0] ta);
		step_t s;
		s = '{kind: K_END, addr: '0, data: '0};
		case (op)
			OP_READ: begin
				if (i == 4'h0) s = '{kind: K_RD, addr: ta, data: '0};
			end
			OP_RESET: begin
				if (i == 4'h0) s = '{kind: K_WR, addr: '0, data: `CMD_RESET};
			end
			OP_ID: begin
				if (i < 4'h3) s = unl(i, bm, `CMD_ID, `CMD_ID);
				else if (i == 4'h3) s = '{kind: K_RD, addr: ta, data: '0};
				else if (i == 4'h4) s = '{kind: K_WR, addr: '0, data: `CMD_RESET};
			end
			OP_ERASE: begin
				if (i < 4'h6) s = unl(i, bm, `CMD_SETUP, `CMD_CHIP_ERASE); // RULE13
				else if (i == 4'h6) s = '{kind: K_POLL, addr: ta, data: '0};
			end
			OP_LV_PROT, OP_LV_UNPROT: begin
				if (i < 4'h6) s = unl(i, bm, `CMD_SETUP, `CMD_PROT_UNLOCK); // RULE9
				else if (i == 4'h6) s.kind = K_LVPULSE;
				else if (i == 4'h7) s.kind = K_LVVER; // RULE10
				else if (i == 4'h8) s = '{kind: K_WR, addr: '0, data: `CMD_RESET};
			end
			OP_HV_PROT, OP_HV_UNPROT: begin
				if (i == 4'h0) s.kind = K_HVPULSE;
				else if (i == 4'h1) s.kind = K_HVRD;
			end
			OP_HV_ID: begin
				if (i == 4'h0) s = '{kind: K_HVRD, addr: ta, data: '0};
			end
			default: s.kind = K_END;
		endcase
		// Protect steps carry the sector, the select line and the mode bits.
		if (s.kind inside {K_LVPULSE, K_HVPULSE, K_LVVER} ||
			(s.kind == K_HVRD && op != OP_HV_ID)) begin
			s.addr[`FA_SEC_HI:`FA_SEC_LO] = ta[`FA_SEC_HI:`FA_SEC_LO];
			s.addr[`FA_A9] = 1'b1;
			s.addr[`FA_A6] = (op == OP_LV_UNPROT || op == OP_HV_UNPROT);
			s.addr[`FA_A1] = (s.kind inside {K_LVVER, K_HVRD});
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer, registers and pin drive
	// ----------------------------------------------------------------

	// Next values for the whole controller.
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		idx_d = idx_q;
		cnt_d = cnt_q;
		adv_d = adv_q;
		byte_d = byte_q;
		taddr_d = taddr_q;
		busy_d = busy_q;
		done_d = done_q;
		fail_d = fail_q;
		poll_d = poll_q;
		tog_d = tog_q;
		tmo_d = tmo_q;
		first_d = first_q;
		polls_d = polls_q;
		data_d = data_q;
		rdata_d = '0;
		cur = step_of(op_q, idx_q, byte_q, taddr_q);
		// Software writes; a start while busy is ignored.
		if (reg_wr && reg_addr == `REG_ADDR && !busy_q) begin
			taddr_d = reg_wdata[18:0];
		end
		case (state_q)
			ST_IDLE: begin
				if (reg_wr && reg_addr == `REG_CTRL) begin
					op_d = op_t'(reg_wdata[3:0]);
					byte_d = reg_wdata[`CTRL_BYTE];
					idx_d = '0;
					busy_d = 1'b1;
					done_d = 1'b0;
					fail_d = 1'b0;
					first_d = 1'b1;
					polls_d = '0;
					cnt_d = SETUP_CYC - 11'd1;
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// Address setup, then strobe or finish.
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 11'd1;
				end else if (cur.kind == K_END) begin
					busy_d = 1'b0;
					done_d = 1'b1;
					state_d = ST_IDLE;
				end else begin
					state_d = ST_ASSERT;
					if (cur.kind inside {K_LVPULSE, K_HVPULSE}) cnt_d = PULSE_CYC - 11'd1;
					else if (cur.kind == K_WR) cnt_d = WE_CYC - 11'd1;
					else cnt_d = RD_CYC - 11'd1;
				end
			end
			ST_ASSERT: begin
				// Strobe low; reads sample the synchronised lines at the end.
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 11'd1;
				end else begin
					state_d = ST_HOLD;
					cnt_d = REC_CYC - 11'd1;
					adv_d = 1'b1;
					if (cur.kind inside {K_RD, K_POLL, K_LVVER, K_HVRD}) begin
						data_d = dq_s2_q;
					end
					if (cur.kind == K_POLL) begin
						poll_d = dq_s2_q[`DQ_POLL];
						tog_d = dq_s2_q[`DQ_TOGGLE];
						tmo_d = dq_s2_q[`DQ_TIMEOUT];
						first_d = 1'b0;
						polls_d = polls_q + 16'd1;
						if (dq_s2_q[`DQ_POLL] && !first_q && dq_s2_q[`DQ_TOGGLE] == tog_q) begin
							adv_d = 1'b1;
						end else if ((dq_s2_q[`DQ_TIMEOUT] && !dq_s2_q[`DQ_POLL]) ||
							polls_q == 16'(MAX_POLLS)) begin
							fail_d = 1'b1;
							op_d = OP_RESET; // RULE4
							idx_d = '0;
							adv_d = 1'b0;
						end else begin
							adv_d = 1'b0;
						end
					end
				end
			end
			ST_HOLD: begin
				// Recovery with address and data still held.
				if (cnt_q != '0) begin
					cnt_d = cnt_q - 11'd1;
				end else begin
					if (adv_q) idx_d = idx_q + 4'd1;
					cnt_d = SETUP_CYC - 11'd1;
					state_d = ST_SETUP;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// Register read data for the cycle after the strobe.
		if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL: rdata_d = {27'h0, byte_q, op_q};
				`REG_ADDR: rdata_d = {13'h0, taddr_q};
				`REG_STATUS: rdata_d = {26'h0, tmo_q, tog_q, poll_q, fail_q, done_q, busy_q};
				`REG_DATA: rdata_d = {16'h0, data_q};
				default: rdata_d = '0;
			endcase
		end
		// Pin drive follows the next state and step.
		nxt = step_of(op_d, idx_d, byte_d, taddr_d);
		pins_d.ce_n = !(state_d == ST_ASSERT);
		pins_d.oe_n = !(state_d == ST_ASSERT && nxt.kind inside {K_RD, K_POLL, K_LVVER, K_HVRD});
		pins_d.we_n = !(state_d == ST_ASSERT && nxt.kind inside {K_WR, K_LVPULSE, K_HVPULSE});
		pins_d.byte_n = !byte_d;
		pins_d.addr = (state_d == ST_IDLE) ? '0 : nxt.addr;
		pins_d.dq_out = {8'h00, nxt.data};
		pins_d.dq_oe_n = !(state_d inside {ST_ASSERT, ST_HOLD} && nxt.kind == K_WR);
		pins_d.id_high_voltage_a9 = state_d != ST_IDLE && nxt.kind inside {K_HVPULSE, K_HVRD};
		pins_d.id_high_voltage_oe = state_d != ST_IDLE && nxt.kind == K_HVPULSE;
		// Command history seen on the pins, for the checks below.
		wr_end = pins_d.we_n && !pins_q.we_n && !pins_q.dq_oe_n;
		hist_d = wr_end ? {hist_q[31:0], pins_q.dq_out[7:0]} : hist_q;
		lvp_d = wr_end ? 1'b0 : lvp_q;
		if (pins_d.we_n && !pins_q.we_n && pins_q.dq_oe_n && !pins_q.id_high_voltage_a9) begin
			lvp_d = 1'b1;
		end
	end

	// Registers of the controller; the data lines pass two flip-flops.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ;
			idx_q <= '0;
			cnt_q <= '0;
			adv_q <= 1'b0;
			byte_q <= 1'b0;
			taddr_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			poll_q <= 1'b0;
			tog_q <= 1'b0;
			tmo_q <= 1'b0;
			first_q <= 1'b1;
			polls_q <= '0;
			data_q <= '0;
			rdata_q <= '0;
			pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1, addr: '0,
				dq_out: '0, dq_oe_n: 1'b1, id_high_voltage_a9: 1'b0,
				id_high_voltage_oe: 1'b0};
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			hist_q <= '0;
			lvp_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			idx_q <= idx_d;
			cnt_q <= cnt_d;
			adv_q <= adv_d;
			byte_q <= byte_d;
			taddr_q <= taddr_d;
			busy_q <= busy_d;
			done_q <= done_d;
			fail_q <= fail_d;
			poll_q <= poll_d;
			tog_q <= tog_d;
			tmo_q <= tmo_d;
			first_q <= first_d;
			polls_q <= polls_d;
			data_q <= data_d;
			rdata_q <= rdata_d;
			pins_q <= pins_d;
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			hist_q <= hist_d;
			lvp_q <= lvp_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign pins = pins_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	// A failed erase is followed by a reset write within a few cycles.
	AST_FAIL_RESET: assert property (@(posedge clk) disable iff (rst) // RULE4
		$rose(fail_q) |-> ##[1:12] (!pins_q.we_n && pins_q.dq_out[7:0] == `CMD_RESET))
		else $error("reset write missing after failure");

	// A low-voltage protect pulse comes right after the protect unlock.
	AST_LV_UNLOCKED: assert property (@(posedge clk) disable iff (rst) // RULE9
		(!pins_q.ce_n && !pins_q.we_n && pins_q.dq_oe_n && !pins_q.id_high_voltage_a9)
		|-> hist_q[7:0] == `CMD_PROT_UNLOCK)
		else $error("protect pulse without unlock");

	// A low-voltage verify read directly follows a low-voltage pulse.
	AST_LV_VERIFY: assert property (@(posedge clk) disable iff (rst) // RULE10
		(!pins_q.oe_n && cur.kind == K_LVVER) |-> lvp_q)
		else $error("verify read not after protect pulse");

	// The chip erase code is preceded by the five exact writes.
	AST_ERASE_ORDER: assert property (@(posedge clk) disable iff (rst) // RULE13
		(!pins_q.we_n && !pins_q.dq_oe_n && pins_q.dq_out[7:0] == `CMD_CHIP_ERASE)
		|-> hist_q == {`CMD_UNLOCK1, `CMD_UNLOCK2, `CMD_SETUP, `CMD_UNLOCK1, `CMD_UNLOCK2})
		else $error("chip erase out of order");

	// Writes of the second unlock code carry the word or byte second unlock address.
	AST_UNLOCK_ADDR: assert property (@(posedge clk) disable iff (rst) // RULE19
		(!pins_q.we_n && !pins_q.dq_oe_n && pins_q.dq_out[7:0] == `CMD_UNLOCK2)
		|-> (byte_q ? pins_q.addr[11:0] == `UL2_B : pins_q.addr[11:1] == `UL2_W))
		else $error("wrong unlock address");

endmodule
`default_nettype wire

// [verif/flash_dev_model.sv]
// Behavioural model of the parallel flash device seen on the controller's pins.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
	parameter logic [15:0] MAKER_CODE  = 16'h005A, // Arbitrary maker code.
	parameter logic [15:0] DEV_CODE    = 16'h3C96, // Arbitrary device code.
	parameter logic [15:0] ARRAY_WORD  = 16'h1234, // Array content before erase.
	parameter int          ERASE_READS = 3         // Status reads an erase lasts.
) (
	input  wire flash_pkg::pins_t pins,
	input  wire logic             fail_mode,
	output logic [15:0]           dq_in,
	output logic [7:0]            err_count
);
	import flash_pkg::*;
	// ----------------------------------------
	// Device state
	// ----------------------------------------
	logic [2:0]  seq_q;                            // Position in the unlock sequence.
	logic        id_q, ul_q, lvok_q, ers_q, ok_v;  // Mode flags.
	logic        erased_q, tog_q, arm_q;           // Erase result, toggle, strobe armed.
	logic [63:0] prot_q;                           // One protect flag per sector.
	int          cnt_q;                            // Reads left in the erase.
	logic [15:0] rd, last_q;                       // Read value and last driven value.
	wire         wstb = pins.ce_n | pins.we_n;     // Write strobe, later of the two.
	wire         rstb = pins.ce_n | pins.oe_n;     // Read strobe.
	wire [7:0]   cmd  = pins.dq_out[7:0];          // Command byte.
	wire u1 = pins.byte_n ? (pins.addr[11:1] == 11'h555) : (pins.addr[11:0] == 12'hAAA);
	wire u2 = pins.byte_n ? (pins.addr[11:1] == 11'h2AA) : (pins.addr[11:0] == 12'h555);
	initial begin
		{seq_q, id_q, ul_q, lvok_q, ers_q, erased_q, tog_q, arm_q} = '0;
		{prot_q, cnt_q, err_count, last_q, ok_v} = '0;
	end
	// A strobe edge only counts once a falling edge has armed it.
	always @(negedge wstb) arm_q = 1'b1;
	// Commands and pulses act on the rising strobe edge.
	always @(posedge wstb) if (arm_q) begin
		arm_q = 1'b0;
		if (pins.dq_oe_n) begin
			// An undriven data bus means a protect pulse.
			if (!pins.addr[10] || (!pins.id_high_voltage_oe && !ul_q)) err_count++;
			else begin
				if (pins.addr[7]) prot_q = '0;
				else prot_q[pins.addr[18:13]] = 1'b1;
				lvok_q = !pins.id_high_voltage_oe;
			end
		end else if (cmd == 8'hF0) begin
			{seq_q, id_q, ul_q, lvok_q, ers_q} = '0;
		end else if (ers_q) err_count++;
		else begin
			case (seq_q)
				3'd0, 3'd3: ok_v = u1 && cmd == 8'hAA;
				3'd1, 3'd4: ok_v = u2 && cmd == 8'h55;
				3'd2: ok_v = u1 && (cmd == 8'h90 || cmd == 8'h80);
				default: ok_v = u1 && (cmd == 8'h10 || cmd == 8'h20);
			endcase
			if (!ok_v) begin
				{seq_q, id_q, ul_q} = '0;
				err_count++;
			end else if (seq_q == 3'd2 && cmd == 8'h90) begin
				id_q = 1'b1;
				seq_q = '0;
			end else if (seq_q == 3'd5) begin
				seq_q = '0;
				ul_q = cmd == 8'h20;
				ers_q = cmd == 8'h10;
				cnt_q = ERASE_READS;
			end else seq_q++;
		end
	end
	// Each status read flips the toggle; the erase ends by itself unless fail_mode is set.
	always @(negedge rstb) if (ers_q) begin
		tog_q = ~tog_q;
		cnt_q = cnt_q - 1;
		if (!fail_mode && cnt_q == 0) begin
			ers_q = 1'b0;
			erased_q = 1'b1;
		end
	end
	// Read data: codes, status or array.
	always_comb begin
		if (pins.id_high_voltage_a9 || id_q || (lvok_q && pins.addr[10])) begin
			rd = pins.addr[2] ? {15'h0, prot_q[pins.addr[18:13]]}
				: (pins.addr[1] ? DEV_CODE : MAKER_CODE);
		end else if (ers_q) rd = {8'h00, 1'b0, tog_q, fail_mode, 5'h00};
		else rd = erased_q ? 16'hFFFF : ARRAY_WORD;
	end
	// A released bus shows the inverse of the last value, not a held one.
	always @(posedge rstb) last_q = rd;
	assign dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~last_q;
endmodule
`default_nettype wire

// [verif/flash_ctl_tb_top.sv]
// Self-checking testbench for the parallel flash controller.
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_tb_top;
	import flash_pkg::*;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	localparam logic [15:0] MAKER = 16'h005A; // Arbitrary maker code.
	localparam logic [15:0] DEV   = 16'h3C96; // Arbitrary device code.
	localparam logic [15:0] ARRAY = 16'h1234; // Array content before erase.
	typedef struct {op_t op; logic bm; logic [18:0] a; logic [15:0] exp;} row_t;
	logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, fail_mode = 0;
	logic [3:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, v;
	logic [15:0] dq_in;
	logic [7:0]  err_count;
	pins_t       pins;
	int          bad_count = 0, total_checks = 0;
	row_t        rows[10];
	always #5 clk = ~clk;
	flash_ctl #(.MAX_POLLS(8)) flash_ctl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pins(pins), .dq_in(dq_in));
	flash_dev_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV), .ARRAY_WORD(ARRAY),
		.ERASE_READS(3)) flash_dev_model_i (.pins(pins), .fail_mode(fail_mode),
		.dq_in(dq_in), .err_count(err_count));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compares one value and counts it.
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// One-cycle register write, issued just after an edge.
	task wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// One-cycle register read; data is taken in the following cycle.
	task rd(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Starts an operation and polls status until it is no longer busy.
	task run(input op_t op, input logic bm, input logic [18:0] a);
		int n;
		n = 0;
		wr(4'h4, {13'h0, a});
		wr(4'h0, {27'h0, bm, op});
		v = 32'h1;
		while (v[0] !== 1'b0 && n < 4000) begin
			rd(4'h8, v);
			n++;
		end
		// A poll limit that runs out is a mismatch of its own.
		if (v[0] !== 1'b0) begin
			bad_count++;
			$display("ERROR t=%0t operation never finished", $time);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Watchdog cuts a hang short.
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		$display("ERROR t=%0t watchdog expired", $time);
		test_done;
	end
	// Main sequence: reset checks, table rows, erase cases, then a mid-run reset.
	initial begin
		rows[0] = '{OP_ID, 1'b0, 19'h0, MAKER};
		rows[1] = '{OP_ID, 1'b0, 19'h2, DEV};
		rows[2] = '{OP_HV_ID, 1'b0, 19'h0, MAKER};
		rows[3] = '{OP_HV_ID, 1'b0, 19'h2, DEV};
		rows[4] = '{OP_HV_PROT, 1'b0, {6'h05, 13'h0}, 16'h0001};
		rows[5] = '{OP_LV_PROT, 1'b1, {6'h2A, 13'h0}, 16'h0001};
		rows[6] = '{OP_HV_ID, 1'b0, {6'h2A, 13'h4}, 16'h0001};
		rows[7] = '{OP_LV_UNPROT, 1'b0, 19'h0, 16'h0000};
		rows[8] = '{OP_HV_ID, 1'b0, {6'h05, 13'h4}, 16'h0000};
		rows[9] = '{OP_READ, 1'b0, 19'h40, ARRAY};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		rd(4'h8, v);
		chk(v, 32'h0, "status after reset");
		rd(4'h2, v);
		chk(v, 32'h0, "unmapped read");
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			run(rows[i].op, rows[i].bm, rows[i].a);
			rd(4'hC, v);
			chk({16'h0, v[15:0]}, {16'h0, rows[i].exp}, "row data");
			$display("row %0d done", i);
		end
		run(OP_RESET, 1'b0, 19'h0);
		run(OP_ERASE, 1'b0, 19'h0);
		rd(4'h8, v);
		// The last poll reads erased array data, all ones, so timeout_bit shows one.
		chk({26'h0, v[5:0]}, 32'h3A, "erase status");
		run(OP_READ, 1'b0, 19'h40);
		rd(4'hC, v);
		chk({16'h0, v[15:0]}, 32'hFFFF, "erased data");
		$display("erase test done");
		fail_mode <= 1'b1;
		run(OP_ERASE, 1'b0, 19'h0);
		rd(4'h8, v);
		chk({28'h0, v[5], v[3], v[2], v[0]}, 32'hA, "failed erase status");
		// Read data stand for one cycle only, then drop back to zero.
		@(posedge clk);
		#1;
		chk(reg_rdata, 32'h0, "read data held too long");
		fail_mode <= 1'b0;
		run(OP_READ, 1'b0, 19'h40);
		rd(4'hC, v);
		chk({16'h0, v[15:0]}, 32'hFFFF, "read after abort");
		chk({24'h0, err_count}, 32'h0, "device protocol errors");
		$display("failure test done");
		// A reset cut into a running read leaves the pins idle and status clear.
		wr(4'h0, {27'h0, 1'b0, OP_READ});
		repeat (5) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk({28'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n}, 32'hF, "pins after reset");
		rd(4'h8, v);
		chk(v, 32'h0, "status after mid-run reset");
		$display("mid-run reset test done");
		test_done;
	end
endmodule
`default_nettype wire
